// ---- vid_seq_pkg.sv ----
/*
 constants, register map and state encodings of the voltage sequencer.
 assumes one 25 MHz clock and an asynchronous active-low power-on reset.
*/
// Function
// - top bit of target code ignored
// - soft-start uses slow slew rate default
// - alert released while transition runs
// - blanking ends 4 us after target reached
// - skip control low in normal operation
// - skip control high on downward change
// - reset clears fault latch, loads defaults
// - no switching while bias undervoltage lockout
// - reference needs sys enable, bias, EN
// - ramp to target at slow slew rate
// - alert signals startup done at target; code drives alert only on ALARM or latched fault, STARTUP_DONE flags done
// - alert released in normal conversion
// - alert low on alarm or fault
package vid_seq_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] SLEW_OFS = 8'h06; // slow slew-rate setting
   localparam logic [7:0] TARGET_OFS = 8'h07; // target-voltage code
   localparam logic [7:0] SLEW_RST = 8'h01; // default slow rate, steps per tick
   localparam logic [7:0] TARGET_RST = 8'h00; // default target code
   localparam logic [6:0] CODE_MASK = 7'h7F; // seven code bits
   // ****************************************
   // setpoint mapping, millivolts
   // ****************************************
   localparam int BASE_MV = 490; // millivolts at code zero, so 0x5E lands on 1430
   localparam int STEP_MV = 10; // millivolts per code step
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 25; // clock rate
   localparam int BLANK_TAIL_NS = 4000; // blanking tail after target reached
   localparam int BLANK_TAIL_CYC = (BLANK_TAIL_NS * CLK_MHZ) / 1000;
   localparam int SLEW_TICK_CYC = 25; // cycles per slew tick, 1 us
   localparam int REF_SETTLE_CYC = 25; // reference settle cycles
   // ****************************************
   // sequencer states, one-hot
   // ****************************************
   typedef enum logic [4:0] {
      ST_OFF = 5'b0_0001,
      ST_REF = 5'b0_0010,
      ST_RAMP = 5'b0_0100,
      ST_TAIL = 5'b0_1000,
      ST_RUN = 5'b1_0000
   } seq_state_t;
   // code to millivolts, used by the sequencer
   function automatic logic [11:0] code_to_mv(input logic [7:0] code);
      code_to_mv = 12'(BASE_MV + STEP_MV * int'(code[6:0]));
   endfunction
endpackage

// ---- vid_slew_ramp.sv ----
/*
 slew ramp: steps the internal setpoint code toward the target.
 assumes the sequencer starts it and supplies a one-cycle tick enable.
*/
`timescale 1ns/10ps
module vid_slew_ramp import vid_seq_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic run, // ramp allowed
   input wire logic tick, // one-cycle slew enable
   input wire logic [7:0] rate, // code steps per tick
   input wire logic [6:0] target, // goal code
   output logic [6:0] dac_code, // present setpoint code
   output logic at_target // setpoint equals goal
);
   logic [6:0] dac_r, dac_nxt; // setpoint code register
   // ****************************************
   // stepper
   // ****************************************
   // step by rate, clamp at goal so no overshoot
   always_comb begin
      dac_nxt = dac_r;
      if (!run) begin
         dac_nxt = 7'h00;
      end else if (tick && dac_r < target) begin
         dac_nxt = (target - dac_r > rate[6:0]) ? 7'(dac_r + rate[6:0]) : target;
      end else if (tick && dac_r > target) begin
         dac_nxt = (dac_r - target > rate[6:0]) ? 7'(dac_r - rate[6:0]) : target;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dac_r <= 7'h00;
      end else begin
         dac_r <= dac_nxt;
      end
   end
   assign dac_code = dac_r;
   assign at_target = (dac_r == target);
endmodule // vid_slew_ramp

// ---- vid_slew_startup_sequencer.sv ----
/*
 startup sequencer, setpoint and alert/skip control of the regulator.
 assumes register writes arrive as a one-cycle strobe from the serial
 interface and that alarm/fault levels are synchronous to MCLK.
*/
`timescale 1ns/10ps
module vid_slew_startup_sequencer import vid_seq_pkg::*; (
   input wire logic MCLK,
   input wire logic ARST_N, // power-on reset
   input wire logic REG_WE, // register write strobe
   input wire logic [7:0] REG_ADDR, // register offset
   input wire logic [7:0] REG_WDATA, // write data
   output logic [7:0] REG_RDATA, // read data
   input wire logic SYS_EN, // system enable
   input wire logic BIAS_OK, // bias above 4.5 V
   input wire logic EN, // enable pin
   input wire logic REF_OK, // reference in regulation
   input wire logic ALARM, // alarm event level
   input wire logic FAULT, // fault condition level
   output logic REF_ON, // reference power up
   output logic SWITCH_EN, // switching allowed
   output logic [11:0] SETPOINT_MV, // setpoint millivolts
   output logic STARTUP_DONE, // startup reached target
   output logic skip_mode_ctrl_n, // skip control to driver
   output logic INT_N_O, // alert pin output value
   output logic INT_N_OE_N // alert drive enable, low drives
);
   // ****************************************
   // registers
   // ****************************************
   logic [7:0] slew_rate_setting_r, slew_nxt; // slow slew rate
   logic [7:0] target_r, target_nxt; // target code
   logic down_r, down_nxt; // downward transition in progress
   logic [6:0] dac_code; // present setpoint code, from the ramp
   logic at_target; // setpoint equals goal, from the ramp
   // register writes; a lower code arms the down flag
   always_comb begin
      slew_nxt = slew_rate_setting_r;
      target_nxt = target_r;
      down_nxt = down_r;
      if (REG_WE && REG_ADDR == SLEW_OFS) begin
         slew_nxt = REG_WDATA;
      end else if (REG_WE && REG_ADDR == TARGET_OFS) begin
         target_nxt = REG_WDATA;
         if ((REG_WDATA[6:0] & CODE_MASK) < dac_code) begin
            down_nxt = 1'b1;
         end
      end
      if (at_target && !(REG_WE && REG_ADDR == TARGET_OFS)) begin
         down_nxt = 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         slew_rate_setting_r <= SLEW_RST;
         target_r <= TARGET_RST;
         down_r <= 1'b0;
      end else begin
         slew_rate_setting_r <= slew_nxt;
         target_r <= target_nxt;
         down_r <= down_nxt;
      end
   end
   // read mux, unmapped offsets read zero
   always_comb begin
      if (REG_ADDR == SLEW_OFS) begin
         REG_RDATA = slew_rate_setting_r;
      end else if (REG_ADDR == TARGET_OFS) begin
         REG_RDATA = target_r;
      end else begin
         REG_RDATA = 8'h00;
      end
   end
   // ****************************************
   // sequencer
   // ****************************************
   seq_state_t st_r, st_nxt; // sequencer state
   logic [7:0] cnt_r, cnt_nxt; // settle / tail counter
   logic [4:0] tick_r, tick_nxt; // slew tick divider
   logic fault_r, fault_nxt; // fault latch
   logic done_r, done_nxt; // startup completed
   logic en_all; // all power-up conditions
   logic ramp_run; // ramp active
   logic tick; // slew enable pulse
   assign en_all = SYS_EN && BIAS_OK && EN;
   assign tick = (tick_r == 5'(SLEW_TICK_CYC - 1));
   assign ramp_run = (st_r == ST_RAMP) || (st_r == ST_TAIL) || (st_r == ST_RUN);
   // state walk; losing any enable drops straight back to off
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      tick_nxt = tick ? 5'h00 : 5'(tick_r + 5'h01);
      fault_nxt = fault_r || FAULT;
      done_nxt = done_r;
      if (!en_all) begin
         st_nxt = ST_OFF;
         cnt_nxt = 8'h00;
         fault_nxt = FAULT; // toggling EN clears the latch
      end else begin
         case (st_r)
            ST_OFF: begin
               st_nxt = ST_REF;
               cnt_nxt = 8'h00;
            end
            ST_REF: begin
               cnt_nxt = 8'(cnt_r + 8'h01);
               if (REF_OK && cnt_r >= 8'(REF_SETTLE_CYC - 1)) begin
                  st_nxt = ST_RAMP;
               end
            end
            ST_RAMP: begin
               cnt_nxt = 8'h00;
               if (at_target) begin
                  st_nxt = ST_TAIL;
               end
            end
            ST_TAIL: begin
               cnt_nxt = 8'(cnt_r + 8'h01);
               if (!at_target) begin
                  st_nxt = ST_RAMP;
               end else if (cnt_r == 8'(BLANK_TAIL_CYC - 1)) begin
                  st_nxt = ST_RUN;
                  done_nxt = 1'b1;
               end
            end
            ST_RUN: begin
               if (!at_target) begin
                  st_nxt = ST_RAMP;
               end
            end
            default: begin
               st_nxt = ST_OFF;
            end
         endcase
      end
   end
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_r <= ST_OFF;
         cnt_r <= 8'h00;
         tick_r <= 5'h00;
         fault_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
         fault_r <= fault_nxt;
         done_r <= done_nxt;
      end
   end
   // ramp uses whatever the slow-rate register holds, its default at startup
   vid_slew_ramp u_ramp (
      .clk(MCLK),
      .arst_n(ARST_N),
      .run(ramp_run),
      .tick(tick),
      .rate(slew_rate_setting_r),
      .target(target_r[6:0]),
      .dac_code(dac_code),
      .at_target(at_target)
   );
   // ****************************************
   // outputs
   // ****************************************
   logic blank; // transition blanking
   logic alert; // alert request
   assign blank = (st_r == ST_RAMP) || (st_r == ST_TAIL);
   assign alert = ALARM || fault_r;
   assign REF_ON = (st_r != ST_OFF);
   assign SWITCH_EN = ramp_run && BIAS_OK && !fault_r;
   assign SETPOINT_MV = code_to_mv({1'b0, dac_code});
   assign STARTUP_DONE = done_r;
   assign skip_mode_ctrl_n = down_r;
   assign INT_N_O = 1'b0;
   assign INT_N_OE_N = blank || !alert;
   // ****************************************
   // checks
   // ****************************************
   // cycles spent in the blanking tail; kept apart from cnt_r so that the
   // length check does not lean on the very counter that it checks
   logic [7:0] tail_age_r, tail_age_nxt; // tail cycles so far
   always_comb begin
      tail_age_nxt = 8'h00;
      if (st_r == ST_TAIL) begin
         tail_age_nxt = 8'(tail_age_r + 8'h01);
      end
   end
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tail_age_r <= 8'h00;
      end else begin
         tail_age_r <= tail_age_nxt;
      end
   end
   sequence s_reach;
      st_r == ST_RAMP ##1 st_r == ST_TAIL;
   endsequence
   sequence s_leave;
      st_r == ST_TAIL ##1 st_r == ST_RUN;
   endsequence
   a_blank_release: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_r == ST_RAMP || st_r == ST_TAIL) |-> INT_N_OE_N) else $error("alert driven while blanking");
   a_reach_age: assert property (@(posedge MCLK) disable iff (!ARST_N)
      s_reach |-> (tail_age_r == 8'h00) && INT_N_OE_N) else $error("tail not restarted");
   a_tail_length: assert property (@(posedge MCLK) disable iff (!ARST_N)
      s_leave |-> $past(tail_age_r) == 8'(BLANK_TAIL_CYC - 1))
      else $error("blank tail length wrong");
   a_tail_bound: assert property (@(posedge MCLK) disable iff (!ARST_N)
      st_r == ST_TAIL |-> tail_age_r < 8'(BLANK_TAIL_CYC)) else $error("blank tail too long");
   a_lockout_off: assert property (@(posedge MCLK) disable iff (!ARST_N)
      !BIAS_OK |-> !SWITCH_EN) else $error("switching under lockout");
   a_ref_needs: assert property (@(posedge MCLK) disable iff (!ARST_N)
      !en_all |=> !REF_ON) else $error("reference on without enables");
   a_fault_alert: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (FAULT && !blank) |=> (fault_r || !en_all)) else $error("fault not latched");
   a_skip_down: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (REG_WE && REG_ADDR == TARGET_OFS && REG_WDATA[6:0] < dac_code) |=> skip_mode_ctrl_n)
      else $error("skip not raised on down step");
   a_skip_idle: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_r == ST_RUN && $stable(target_r) && at_target
      && !(REG_WE && REG_ADDR == TARGET_OFS)) |=> !skip_mode_ctrl_n)
      else $error("skip high at rest");
   a_done_sets: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_r == ST_TAIL && $past(st_r) == ST_TAIL) ##1 st_r == ST_RUN |-> STARTUP_DONE)
      else $error("done not set at run");
   a_mv_top: assert property (@(posedge MCLK) disable iff (!ARST_N)
      dac_code == 7'h7F |-> SETPOINT_MV == 12'h6E0) else $error("top code wrong");
endmodule // vid_slew_startup_sequencer

// ---- vid_far_side.sv ----
/*
 far side model: reference settle and the alert pull-up.
 assumes the sequencer's reference and alert ports on one clock.
*/
`timescale 1ns/10ps
module vid_far_side #(
   parameter int SETTLE = 3 // cycle count must pass this value before the reference is good
) (
   input wire logic clk,
   input wire logic ref_on,
   input wire logic int_o,
   input wire logic int_oe_n,
   output logic ref_ok,
   output wire alert_pin
);
   // ************
   // reference settle, slow or prompt by SETTLE
   // ************
   logic [3:0] cnt; // cycles since power up
   always @(posedge clk) begin
      cnt <= ref_on ? cnt + 4'(cnt != 4'hF) : 4'h0;
      ref_ok <= ref_on && (cnt > 4'(SETTLE));
   end
   // pull-up wins whenever the pin is let go
   assign alert_pin = int_oe_n ? 1'b1 : int_o;
endmodule // vid_far_side

// ---- tb.sv ----
/*
 self-checking bench of the sequencer.
 assumes the far-side model and a 25 MHz clock.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
   // ************
   // stimulus, notes and counters
   // ************
   logic MCLK, ARST_N, REG_WE, SYS_EN, BIAS_OK, EN, ALARM, FAULT, REF_OK;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, lfsr, t;
   logic REF_ON, SWITCH_EN, STARTUP_DONE, skip_mode_ctrl_n, INT_N_O, INT_N_OE_N;
   logic [11:0] SETPOINT_MV;
   wire alert_pin;
   int num_errors, compares, waited;
   typedef struct {int sel; logic [11:0] val;} note_t;
   note_t notes[$]; // oldest expectation first
   event sample;
   vid_slew_startup_sequencer dut (.MCLK(MCLK), .ARST_N(ARST_N), .REG_WE(REG_WE),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .SYS_EN(SYS_EN), .BIAS_OK(BIAS_OK), .EN(EN), .REF_OK(REF_OK), .ALARM(ALARM),
      .FAULT(FAULT), .REF_ON(REF_ON), .SWITCH_EN(SWITCH_EN), .SETPOINT_MV(SETPOINT_MV),
      .STARTUP_DONE(STARTUP_DONE), .skip_mode_ctrl_n(skip_mode_ctrl_n),
      .INT_N_O(INT_N_O), .INT_N_OE_N(INT_N_OE_N));
   vid_far_side far (.clk(MCLK), .ref_on(REF_ON), .int_o(INT_N_O),
      .int_oe_n(INT_N_OE_N), .ref_ok(REF_OK), .alert_pin(alert_pin));
   initial begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end
   // pseudo-random bytes, fixed start
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   // selects which output a note speaks of
   function automatic logic [11:0] obs(int s);
      case (s)
         0: obs = {4'h0, REG_RDATA};
         1: obs = SETPOINT_MV;
         2: obs = {11'h0, STARTUP_DONE};
         3: obs = {11'h0, skip_mode_ctrl_n};
         4: obs = {11'h0, alert_pin};
         5: obs = {11'h0, REF_ON};
         default: obs = {11'h0, SWITCH_EN};
      endcase
   endfunction
   // monitor: oldest note against the output now shown
   always begin
      @(sample);
      `CHK(obs(notes[0].sel), notes[0].val)
      void'(notes.pop_front());
   end
   task automatic note(int s, logic [11:0] v);
      notes.push_back('{s, v});
      ->sample;
      #1;
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge MCLK);
   endtask
   // one-cycle write strobe, launched off the sampling edge
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge MCLK);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WE = 1'b1;
      @(negedge MCLK);
      REG_WE = 1'b0;
   endtask
   task automatic rd_note(logic [7:0] a, logic [11:0] v);
      @(negedge MCLK);
      REG_ADDR = a;
      #1 note(0, v);
   endtask
   // bounded wait for the ramp to land
   task automatic wait_mv(logic [11:0] v);
      for (waited = 0; waited < 5000 && SETPOINT_MV !== v; waited++) cyc(1);
      if (waited == 5000) begin
         num_errors++;
         $display("unexpected at %0t: setpoint stuck", $time);
      end
   endtask
   task automatic close_out;
      $display("compares %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // watchdog: the run needs well under 8000 cycles
   initial begin
      #(40 * 20000);
      num_errors++;
      close_out;
   end
   // ************
   // main sequence
   // ************
   initial begin
      {REG_WE, SYS_EN, BIAS_OK, EN, ALARM, FAULT} = 6'b01_0100;
      {ARST_N, REG_ADDR, REG_WDATA, lfsr} = {1'b0, 16'h0000, 8'h5E};
      repeat (6) @(posedge MCLK);
      @(negedge MCLK) ARST_N = 1'b1;
      rd_note(8'h06, 12'h001);
      rd_note(8'h07, 12'h000);
      note(1, 12'h1EA);
      repeat (6) begin
         t = rnd(); // stray offsets must not land
         if (t[7:1] != 7'h03) wr(t, rnd());
      end
      rd_note(8'h06, 12'h001);
      t = rnd(); // random top bit on the target
      wr(8'h07, {t[7], 7'h5E});
      cyc(40);
      note(5, 12'h000);
      note(6, 12'h000);
      $display("test lockout done");
      ALARM = 1'b1;
      BIAS_OK = 1'b1;
      cyc(3);
      note(5, 12'h001);
      cyc(40);
      note(4, 12'h001);
      note(3, 12'h000);
      note(6, 12'h001);
      wait_mv(12'h596);
      note(1, 12'h596);
      `CHK(waited > 2000, 1'b1)
      cyc(90);
      note(4, 12'h001);
      note(2, 12'h000);
      cyc(20);
      note(4, 12'h000);
      note(2, 12'h001);
      ALARM = 1'b0;
      cyc(1);
      note(4, 12'h001);
      $display("test startup done");
      wr(8'h06, 8'h08);
      wr(8'h07, 8'h7F);
      wait_mv(12'h6E0);
      note(1, 12'h6E0);
      note(3, 12'h000);
      wr(8'h07, 8'h5E);
      cyc(1);
      note(3, 12'h001);
      wait_mv(12'h596);
      cyc(2);
      note(3, 12'h000);
      $display("test transitions done");
      cyc(120);
      FAULT = 1'b1;
      cyc(1);
      FAULT = 1'b0;
      cyc(2);
      note(4, 12'h000);
      EN = 1'b0;
      cyc(2);
      note(5, 12'h000);
      note(4, 12'h001);
      $display("test fault done");
      close_out;
   end
endmodule // tb
